// >>> core/ast_pkg.sv
// Purpose: shared constants and types of the acquisition strobe timer
// Assumes: 250 MHz clock, 32-bit plain register port
// Notes:   all durations are kept in microseconds and counted on a 1 us tick
package ast_pkg;
  // register port widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  typedef logic [ADDR_W-1:0] ast_addr_t;
  typedef logic [DATA_W-1:0] ast_data_t;

  // one register access as the master presents it
  typedef struct packed {
    logic      wr;     // write strobe
    logic      rd;     // read strobe
    ast_addr_t addr;   // byte address
    ast_data_t wdata;  // write data
  } ast_bus_req_t;

  // the two strobe outputs
  typedef struct packed {
    logic single;      // one-shot strobe
    logic periodic;    // periodic strobe
  } ast_strobes_t;

  // register byte offsets
  localparam ast_addr_t OFS_CTRL     = 5'h00;
  localparam ast_addr_t OFS_STATUS   = 5'h04;
  localparam ast_addr_t OFS_ACQ_WAIT = 5'h08;
  localparam ast_addr_t OFS_EXPOSURE = 5'h0C;
  localparam ast_addr_t OFS_PDELAY   = 5'h10;
  localparam ast_addr_t OFS_PWIDTH   = 5'h14;
  localparam ast_addr_t OFS_PERIOD   = 5'h18;

  // control field positions
  localparam int CTRL_TRIG_BIT = 0;  // write 1 to trigger, reads 0
  localparam int CTRL_SEN_BIT  = 1;  // one-shot strobe enable
  localparam int CTRL_PEN_BIT  = 2;  // periodic strobe enable
  // status field positions
  localparam int STAT_BUSY_BIT = 3;  // state in bits 2:0

  // reset values
  localparam int RST_EXPOSURE_US = 1;
  localparam int RST_ZERO        = 0;

  // timing in microseconds, clock in MHz, tick length in cycles
  localparam int TICK_US         = 1;
  localparam int CLK_MHZ         = 250;
  localparam int TICK_CYC        = TICK_US * CLK_MHZ;
  localparam int ACQ_WAIT_MAX_US = 335500;
  localparam int EXPOSURE_MIN_US = 1;
  localparam int PRE_BUSY_MIN_US = 1;
  localparam int PRE_KNEE_US     = 218;
  localparam int PRE_BASE_US     = 219;
  localparam int POST_BUSY_US    = 218;

  // acquisition phases, gray along idle, wait, pre, expose, post
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_WAIT   = 3'h1,
    ST_PRE    = 3'h3,
    ST_EXPOSE = 3'h2,
    ST_POST   = 3'h6
  } ast_state_t;
endpackage : ast_pkg

// >>> core/ast_timer.sv
// Purpose: acquisition cycle sequencer with one-shot and periodic strobes
// Assumes: software trigger only; config held steady during a cycle
// Notes:   outputs are registered and aligned with the phase register
`timescale 1ns/100ps
module ast_timer #(
  parameter int CNT_W = 24                 // width of the us counters; time since trigger has one bit more
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ast_pkg::ast_bus_req_t busReq,
  output ast_pkg::ast_data_t         rdData,
  output ast_pkg::ast_strobes_t      strobes,
  output logic                       busy
);
  import ast_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYC);

  // refuse counters too narrow for the exposure range or the wait limit
  if (CNT_W < 23 || CNT_W > 31) begin : g_bad_width
    $error("CNT_W must lie between 23 and 31");
  end

  // configuration and state registers
  logic [CNT_W-1:0] acq_q,  acq_d;        // wait before pre busy
  logic [CNT_W-1:0] expo_q, expo_d;       // exposure length
  logic [CNT_W-1:0] dly_q,  dly_d;        // one-shot delay
  logic [CNT_W-1:0] wid_q,  wid_d;        // one-shot width
  logic [CNT_W-1:0] per_q,  per_d;        // periodic period
  logic             sEn_q,  sEn_d;        // one-shot enable
  logic             pEn_q,  pEn_d;        // periodic enable
  ast_state_t       state_q, state_d;     // acquisition phase
  logic [CNT_W-1:0] cnt_q,  cnt_d;        // us spent in phase
  logic [CNT_W:0]   elUs_q, elUs_d;       // us since trigger
  logic [CNT_W-1:0] pCnt_q, pCnt_d;       // us inside period
  logic             pRun_q, pRun_d;       // periodic allowed
  logic [PRE_W-1:0] pre_q,  pre_d;        // tick prescaler
  ast_data_t        rd_q,   rd_d;         // read data
  ast_strobes_t     str_q,  str_d;        // strobe outputs
  logic             busy_q, busy_d;       // cycle running

  // helpers
  logic             tick;                 // 1 us pulse
  logic             trigAcc;              // trigger taken
  logic [CNT_W-1:0] cntInc;               // phase count plus one
  logic [CNT_W-1:0] preLen;               // pre busy length
  logic [CNT_W-1:0] wrVal;                // write data cut to width
  logic             wrHit;                // any write

  assign tick    = (pre_q == PRE_W'(TICK_CYC - 1));
  assign cntInc  = cnt_q + CNT_W'(1);
  assign wrVal   = busReq.wdata[CNT_W-1:0];
  assign wrHit   = busReq.wr;
  assign trigAcc = wrHit && busReq.addr == OFS_CTRL && busReq.wdata[CTRL_TRIG_BIT]
                   && state_q == ST_IDLE;
  // short exposures stretch the pre busy so exposure end stays fixed
  assign preLen  = (expo_q >= CNT_W'(PRE_KNEE_US)) ? CNT_W'(PRE_BUSY_MIN_US)
                   : CNT_W'(PRE_BASE_US) - expo_q;

  // register writes; data cut to CNT_W bits, then wait and exposure are clamped
  always_comb begin
    acq_d  = acq_q;
    expo_d = expo_q;
    dly_d  = dly_q;
    wid_d  = wid_q;
    per_d  = per_q;
    sEn_d  = sEn_q;
    pEn_d  = pEn_q;
    if (wrHit) begin
      case (busReq.addr)
        OFS_CTRL: begin
          sEn_d = busReq.wdata[CTRL_SEN_BIT];
          pEn_d = busReq.wdata[CTRL_PEN_BIT];
        end
        OFS_ACQ_WAIT: begin
          // wait is capped at its largest legal value
          acq_d = (wrVal > CNT_W'(ACQ_WAIT_MAX_US)) ? CNT_W'(ACQ_WAIT_MAX_US) : wrVal;
        end
        OFS_EXPOSURE: begin
          // zero exposure is raised to the shortest one
          expo_d = (wrVal < CNT_W'(EXPOSURE_MIN_US)) ? CNT_W'(EXPOSURE_MIN_US) : wrVal;
        end
        OFS_PDELAY: dly_d = wrVal;
        OFS_PWIDTH: wid_d = wrVal;
        OFS_PERIOD: per_d = wrVal;
        default:    ;                   // unmapped writes are dropped
      endcase
    end
  end

  // read mux, answer in the next cycle only
  always_comb begin
    rd_d = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        OFS_CTRL:     rd_d = DATA_W'({pEn_q, sEn_q, 1'b0});
        OFS_STATUS:   rd_d = DATA_W'({busy_q, state_q});
        OFS_ACQ_WAIT: rd_d = DATA_W'(acq_q);
        OFS_EXPOSURE: rd_d = DATA_W'(expo_q);
        OFS_PDELAY:   rd_d = DATA_W'(dly_q);
        OFS_PWIDTH:   rd_d = DATA_W'(wid_q);
        OFS_PERIOD:   rd_d = DATA_W'(per_q);
        default:      rd_d = '0;        // unmapped reads give zero
      endcase
    end
  end

  // sequencer, counters and strobe levels
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pCnt_d  = pCnt_q;
    pRun_d  = pRun_q;
    // prescaler restarts on trigger so every interval is whole us
    pre_d   = (trigAcc || tick) ? '0 : pre_q + PRE_W'(1);
    // time since trigger, saturating
    elUs_d  = elUs_q;
    if (trigAcc) begin
      elUs_d = '0;
    end else if (tick && state_q != ST_IDLE && !(&elUs_q)) begin
      elUs_d = elUs_q + (CNT_W+1)'(1);
    end
    case (state_q)
      ST_IDLE: begin
        // zero wait goes straight into pre busy
        if (trigAcc) begin
          state_d = (acq_q != '0) ? ST_WAIT : ST_PRE;
          cnt_d   = '0;
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (cntInc >= acq_q) begin
            state_d = ST_PRE;
            cnt_d   = '0;
          end else begin
            cnt_d = cntInc;
          end
        end
      end
      ST_PRE: begin
        if (tick) begin
          if (cntInc >= preLen) begin
            state_d = ST_EXPOSE;
            cnt_d   = '0;
            pCnt_d  = '0;
            // periodic only if enabled and the period is nonzero and shorter than the exposure
            pRun_d  = pEn_q && per_q != '0 && per_q < expo_q;
          end else begin
            cnt_d = cntInc;
          end
        end
      end
      ST_EXPOSE: begin
        if (tick) begin
          if (cntInc >= expo_q) begin
            state_d = ST_POST;
            cnt_d   = '0;
            pRun_d  = 1'b0;
          end else begin
            cnt_d = cntInc;
            if (pCnt_q + CNT_W'(1) == per_q) begin
              pCnt_d = '0;
              // next period starts only if it can finish in time
              pRun_d = pRun_q && ({1'b0, cntInc} + {1'b0, per_q} <= {1'b0, expo_q});
            end else begin
              pCnt_d = pCnt_q + CNT_W'(1);
            end
          end
        end
      end
      ST_POST: begin
        if (tick) begin
          if (cntInc >= CNT_W'(POST_BUSY_US)) begin
            state_d = ST_IDLE;
            cnt_d   = '0;
          end else begin
            cnt_d = cntInc;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = '0;
        pRun_d  = 1'b0;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
    // one-shot high from delay for width, cut off once exposure ends
    str_d.single = sEn_q && (state_d == ST_WAIT || state_d == ST_PRE || state_d == ST_EXPOSE)
                   && elUs_d >= {1'b0, dly_q}
                   && (elUs_d - {1'b0, dly_q}) < {1'b0, wid_q};
    // periodic high in the first half of each allowed period, rounded up to whole us
    str_d.periodic = (state_d == ST_EXPOSE) && pRun_d
                     && ({pCnt_d, 1'b0} < {1'b0, per_q});
  end

  // all state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acq_q   <= '0;
      expo_q  <= CNT_W'(RST_EXPOSURE_US);
      dly_q   <= '0;
      wid_q   <= '0;
      per_q   <= '0;
      sEn_q   <= 1'b0;
      pEn_q   <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      elUs_q  <= '0;
      pCnt_q  <= '0;
      pRun_q  <= 1'b0;
      pre_q   <= '0;
      rd_q    <= '0;
      str_q   <= '0;
      busy_q  <= 1'b0;
    end else begin
      acq_q   <= acq_d;
      expo_q  <= expo_d;
      dly_q   <= dly_d;
      wid_q   <= wid_d;
      per_q   <= per_d;
      sEn_q   <= sEn_d;
      pEn_q   <= pEn_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
      elUs_q  <= elUs_d;
      pCnt_q  <= pCnt_d;
      pRun_q  <= pRun_d;
      pre_q   <= pre_d;
      rd_q    <= rd_d;
      str_q   <= str_d;
      busy_q  <= busy_d;
    end
  end

  assign rdData  = rd_q;
  assign strobes = str_q;
  assign busy    = busy_q;

  // checks on the sequencer and the strobes
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wait_entry: assert property (trigAcc && acq_q != '0 |=> state_q == ST_WAIT)
    else $error("nonzero wait did not enter wait phase");
  a_wait_skip: assert property (trigAcc && acq_q == '0 |=> state_q == ST_PRE)
    else $error("zero wait did not go to pre busy");
  a_pre_length: assert property (state_q == ST_PRE && tick && cntInc < preLen |=> state_q == ST_PRE)
    else $error("pre busy ended early");
  a_post_length: assert property (state_q == ST_POST && tick && cntInc == CNT_W'(POST_BUSY_US)
    |=> state_q == ST_IDLE && !busy)
    else $error("post busy length wrong");
  a_single_cutoff: assert property (state_q == ST_POST |-> !strobes.single)
    else $error("one-shot high after exposure");
  a_periodic_gate: assert property (strobes.periodic |-> per_q < expo_q && per_q != '0)
    else $error("periodic active with period not below exposure");
  a_expose_order: assert property ($rose(state_q == ST_EXPOSE) |-> $past(state_q) == ST_PRE
    && $past(tick))
    else $error("exposure not preceded by pre busy");
  a_single_rise: assert property ($rose(strobes.single) |-> elUs_q >= {1'b0, dly_q})
    else $error("one-shot rose before its delay");
  a_periodic_window: assert property (strobes.periodic |-> state_q == ST_EXPOSE
    && {1'b0, cnt_q} + {1'b0, per_q} - {1'b0, pCnt_q} <= {1'b0, expo_q})
    else $error("periodic strobe outside a whole period");
  a_tick_gap: assert property (tick |=> !tick [*8])
    else $error("tick spacing too short");

  c_full_cycle: cover property (state_q == ST_POST ##1 state_q == ST_IDLE);
  c_single_high: cover property ($rose(strobes.single));
  c_periodic_high: cover property ($fell(strobes.periodic) && state_q == ST_EXPOSE);
  c_zero_wait: cover property (trigAcc && acq_q == '0);
endmodule : ast_timer

// >>> bench/ast_strobe_sink.sv
// Purpose: external instrument that takes both strobe outputs
// Assumes: strobes are active high levels, registered on clk
// Notes:   counts rising edges so the bench sees whole pulses only
`timescale 1ns/100ps
module ast_strobe_sink (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ast_pkg::ast_strobes_t strobes,
  output int                         singleRises_q,
  output int                         periodicRises_q
);
  import ast_pkg::*;
  ast_strobes_t last_q;  // levels seen at the previous edge
  // count every low-to-high step of each strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q          <= '0;
      singleRises_q   <= 0;
      periodicRises_q <= 0;
    end else begin
      last_q <= strobes;
      if (strobes.single && !last_q.single) begin
        singleRises_q <= singleRises_q + 1;
      end
      if (strobes.periodic && !last_q.periodic) begin
        periodicRises_q <= periodicRises_q + 1;
      end
    end
  end
endmodule : ast_strobe_sink

// >>> bench/ast_timer_tb_top.sv
// Purpose: self-checking bench of the acquisition strobe timer
// Assumes: 250 clocks per microsecond, trigger via control register
// Notes:   a full cycle is too long to finish, so runs are cut by reset
`timescale 1ns/100ps
module ast_timer_tb_top;
  import ast_pkg::*;
  logic         clk;            // 250 MHz clock
  logic         rst;            // async reset
  ast_bus_req_t busReq;         // register port request
  ast_data_t    rdData;         // register read data
  ast_strobes_t strobes;        // strobe outputs
  logic         busy;           // cycle running
  int           singleRises;    // one-shot pulses seen
  int           periodicRises;  // periodic pulses seen
  int           nFail;          // mismatches
  int           totalChecks;    // comparisons made
  time          t0;             // edge that took the last write
  time          tA;             // saved trigger edge
  ast_data_t    got;            // value read back
  // register table rows: address, write value, read-back value
  ast_addr_t rowAddr [7] = '{OFS_ACQ_WAIT, OFS_ACQ_WAIT, OFS_EXPOSURE, OFS_PDELAY, OFS_PWIDTH, OFS_PERIOD, 5'h1C};
  ast_data_t rowWr   [7] = '{32'h5, 32'h61A80, 32'h0, 32'h7, 32'h9, 32'h3, 32'h55};
  ast_data_t rowExp  [7] = '{32'h5, 32'h51E8C, 32'h1, 32'h7, 32'h9, 32'h3, 32'h0};

  ast_timer dut_u (.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData), .strobes(strobes), .busy(busy));
  ast_strobe_sink sink_u (.clk(clk), .rst(rst), .strobes(strobes), .singleRises_q(singleRises),
                          .periodicRises_q(periodicRises));

  // free running clock
  always #2 clk = ~clk;

  // compare and count
  task automatic check(input ast_data_t seen, input ast_data_t exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write; t0 is the edge that takes it
  task automatic wrReg(input ast_addr_t a, input ast_data_t d);
    @(posedge clk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    busReq.wr <= 1'b0;
    t0 = $time;
  endtask : wrReg

  // one-cycle read; data stands in the following cycle only
  task automatic rdReg(input ast_addr_t a, output ast_data_t d);
    @(posedge clk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask : rdReg

  // move to the middle of microsecond u after the trigger, off any edge
  task automatic atUs(input int u);
    #((t0 + u * 1000 + 501) - $time);
  endtask : atUs

  // busy and both strobes against expectation
  task automatic strobeCheck(input logic eB, input logic eS, input logic eP);
    check({29'h0, busy, strobes}, {29'h0, eB, eS, eP});
  endtask : strobeCheck

  // hold reset for 20 cycles; outputs must be low at once
  task automatic doReset;
    @(posedge clk);
    rst <= 1'b1;
    #1 strobeCheck(1'b0, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask : doReset

  // print counts and verdict, end the run
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : giveVerdict

  // hang guard
  initial begin
    #400000;
    nFail++;
    giveVerdict();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    busReq = '0;
    nFail = 0;
    totalChecks = 0;
    t0 = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // reset values
    rdReg(OFS_EXPOSURE, got);
    check(got, 32'h1);
    rdReg(OFS_STATUS, got);
    check(got, 32'h0);
    // register rows, clamp and unmapped place included
    for (int i = 0; i < 7; i++) begin
      wrReg(rowAddr[i], rowWr[i]);
      rdReg(rowAddr[i], got);
      check(got, rowExp[i]);
    end
    // wait 5, long exposure: one-shot from trigger, periodic from exposure start
    wrReg(OFS_ACQ_WAIT, 32'h5);
    wrReg(OFS_EXPOSURE, 32'h12C);
    wrReg(OFS_PDELAY, 32'h2);
    wrReg(OFS_PWIDTH, 32'h3);
    wrReg(OFS_PERIOD, 32'h3);
    wrReg(OFS_CTRL, 32'h7);
    for (int u = 0; u < 12; u++) begin
      atUs(u);
      strobeCheck(1'b1, u >= 2 && u < 5, u >= 6 && (u - 6) % 3 < 2);
    end
    check(singleRises, 1);
    check(periodicRises, 2);
    // second trigger while busy has no effect
    tA = t0;
    wrReg(OFS_CTRL, 32'h7);
    t0 = tA;
    rdReg(OFS_STATUS, got);
    check(got, 32'hA);
    atUs(15);
    strobeCheck(1'b1, 1'b0, 1'b1);
    doReset();
    // short exposure: long pre busy, strobe cut at exposure end, one whole period
    wrReg(OFS_EXPOSURE, 32'h4);
    wrReg(OFS_PWIDTH, 32'h3E8);
    wrReg(OFS_PERIOD, 32'h3);
    wrReg(OFS_CTRL, 32'h7);
    for (int u = 214; u < 220; u++) begin
      atUs(u);
      strobeCheck(1'b1, u < 219, u >= 215 && u < 217);
    end
    rdReg(OFS_STATUS, got);
    check(got, 32'hE);
    check(singleRises, 1);
    check(periodicRises, 1);
    doReset();
    // period equal to exposure: periodic stays off, zero width never pulses
    wrReg(OFS_EXPOSURE, 32'h12C);
    wrReg(OFS_PERIOD, 32'h12C);
    wrReg(OFS_CTRL, 32'h7);
    // trigger bit reads back as zero, read data stands one cycle only
    rdReg(OFS_CTRL, got);
    check(got, 32'h6);
    @(posedge clk);
    #1 check(rdData, 32'h0);
    for (int u = 1; u < 4; u++) begin
      atUs(u);
      strobeCheck(1'b1, 1'b0, 1'b0);
    end
    check(singleRises, 0);
    check(periodicRises, 0);
    giveVerdict();
  end
endmodule : ast_timer_tb_top
